// *** rtl/gpt_pkg.sv ***
// Purpose: shared constants and types for the general purpose timer
// Assumes: 32-bit AHB-Lite register bus, one clock
// Notes: word offsets are byte addresses
package gpt_pkg;
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_PSC = 8'h04;
	localparam logic [7:0] OFF_ARR = 8'h08;
	localparam logic [7:0] OFF_CNT = 8'h0C;
	localparam logic [7:0] OFF_STAT = 8'h10;
	localparam logic [7:0] OFF_MASK = 8'h14;
	localparam logic [7:0] OFF_CHCFG = 8'h18;
	localparam logic [7:0] OFF_CCR0 = 8'h20;
	localparam int NCH = 4;
	localparam int CTRL_EN = 0;
	localparam int CTRL_MODE = 1;
	localparam int CTRL_FRZ = 3;
	localparam int CTRL_SRC = 4;
	localparam int CTRL_OPM = 6;
	localparam int ST_UPD = 0;
	localparam int ST_CC0 = 1;
	localparam logic [1:0] MODE_UP = 2'h0;
	localparam logic [1:0] MODE_DOWN = 2'h1;
	localparam logic [1:0] MODE_CTR = 2'h2;
	localparam logic [1:0] SRC_INT = 2'h0;
	localparam logic [1:0] SRC_ENC = 2'h1;
	localparam logic [1:0] SRC_TRG = 2'h2;
	localparam logic [1:0] SRC_HALL = 2'h3;
	localparam logic [2:0] CH_CAP = 3'h0;
	localparam logic [2:0] CH_CMP = 3'h1;
	localparam logic [2:0] CH_PWM = 3'h2;
	localparam logic [2:0] CH_OPM = 3'h3;
	localparam logic [31:0] ARR_RST = 32'hFFFFFFFF;
	typedef struct packed {
		logic [1:0] htrans;
		logic hwrite;
		logic [7:0] addr;
	} gpt_req_t;
endpackage : gpt_pkg

// *** rtl/gpt_timer.sv ***
// Purpose: general purpose timer with prescaler, four channels, encoder and hall inputs
// Assumes: single clock clk, AHB-Lite slave with zero wait states
// Notes: WIDE selects 32 or 16 bit counter
`timescale 1ns/1ps
`default_nettype none
module gpt_timer import gpt_pkg::*; #(
	parameter bit WIDE = 1'b1
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// channel pins
	input wire logic [3:0] ch_in,
	output logic [3:0] ch_out,
	output logic [3:0] ch_oe_n,
	// system
	input wire logic dbg_halt,
	input wire logic trig_in,
	output logic trig_out,
	output logic [4:0] dma_req,
	output logic irq
);
	localparam logic [31:0] CMASK = WIDE ? 32'hFFFFFFFF : 32'h0000FFFF;
	gpt_req_t req;
	logic [31:0] ctrl, next_ctrl, arr, next_arr, cnt, next_cnt, chcfg, next_chcfg;
	logic [15:0] psc, next_psc, pcnt, next_pcnt;
	logic [4:0] stat, next_stat, mask, next_mask;
	logic [31:0] ccr [NCH];
	logic [31:0] next_ccr [NCH];
	logic [3:0] next_out;
	logic [3:0] ch_q;
	logic dir, next_dir, tick, upd, wr_ph, s1, s2, s3;
	logic [1:0] mode, src;
	logic [4:0] ev;
	logic [7:0] waddr;
	logic [31:0] rdata_n;

	function automatic logic [2:0] ch_mode(input logic [31:0] cfg, input int i);
		ch_mode = cfg[i*4 +: 3];
	endfunction : ch_mode

	assign mode = ctrl[CTRL_MODE +: 2];
	assign src = ctrl[CTRL_SRC +: 2];
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign irq = |(stat & mask);
	assign dma_req = stat & mask;
	assign ch_out = ch_q;

	// pins are asynchronous: two flops before use, third for edges
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
		end else begin
			s1 <= trig_in;
			s2 <= s1;
			s3 <= s2;
		end
	end

	logic [3:0] p1, p2, p3;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			p1 <= 4'h0;
			p2 <= 4'h0;
			p3 <= 4'h0;
		end else begin
			p1 <= ch_in;
			p2 <= p1;
			p3 <= p2;
		end
	end

	logic trg_s, trg_p, enc_a_e, enc_b_e, hall_e;
	assign trg_s = s2;
	assign trg_p = s3;
	assign enc_a_e = p2[0] ^ p3[0];
	assign enc_b_e = p2[1] ^ p3[1];
	assign hall_e = |(p2[2:0] ^ p3[2:0]);

	// prescaler tick; encoder and hall/trigger sources bypass the internal clock
	logic run, frozen;
	assign frozen = dbg_halt && ctrl[CTRL_FRZ];
	assign run = ctrl[CTRL_EN] && !frozen;
	always_comb begin
		next_pcnt = pcnt;
		tick = 1'b0;
		if (run) begin
			case (src)
				SRC_INT: begin
					if (pcnt >= psc) begin
						next_pcnt = 16'h0000;
						tick = 1'b1;
					end else begin
						next_pcnt = pcnt + 16'h0001;
					end
				end
				SRC_ENC: tick = enc_a_e || enc_b_e;
				SRC_TRG: tick = trg_s && !trg_p;
				SRC_HALL: tick = hall_e;
				default: tick = 1'b0;
			endcase
		end
	end

	// counter
	logic cnt_up;
	always_comb begin
		next_cnt = cnt;
		next_dir = dir;
		upd = 1'b0;
		case (src == SRC_ENC ? MODE_CTR : mode)
			MODE_UP: cnt_up = 1'b1;
			MODE_DOWN: cnt_up = 1'b0;
			default: cnt_up = !dir;
		endcase
		if (src == SRC_ENC) begin
			// phase: A edge with A==B means down
			cnt_up = enc_a_e ? (p2[0] != p2[1]) : (p2[0] == p2[1]);
		end
		if (tick) begin
			if (cnt_up) begin
				if (cnt >= (arr & CMASK)) begin
					upd = 1'b1;
					if (mode == MODE_CTR && src != SRC_ENC) begin
						next_dir = 1'b1;
						next_cnt = (cnt - 32'h1) & CMASK;
					end else begin
						next_cnt = 32'h0;
					end
				end else begin
					next_cnt = (cnt + 32'h1) & CMASK;
				end
			end else begin
				if (cnt == 32'h0) begin
					upd = 1'b1;
					if (mode == MODE_CTR && src != SRC_ENC) begin
						next_dir = 1'b0;
						next_cnt = 32'h1 & CMASK;
					end else begin
						next_cnt = arr & CMASK;
					end
				end else begin
					next_cnt = (cnt - 32'h1) & CMASK;
				end
			end
		end
	end
	assign trig_out = upd;

	// channels
	logic [3:0] cap_ev, cmp_ev;
	genvar gi;
	generate
		for (gi = 0; gi < NCH; gi++) begin : g_ch
			logic edge_in;
			assign edge_in = p2[gi] && !p3[gi];
			always_comb begin
				cap_ev[gi] = 1'b0;
				cmp_ev[gi] = 1'b0;
				next_ccr[gi] = ccr[gi];
				next_out[gi] = ch_q[gi];
				case (ch_mode(chcfg, gi))
					CH_CAP: begin
						if (edge_in) begin
							cap_ev[gi] = 1'b1;
							next_ccr[gi] = cnt;
						end
					end
					CH_CMP: begin
						if (tick && next_cnt == ccr[gi]) begin
							cmp_ev[gi] = 1'b1;
							next_out[gi] = !ch_q[gi];
						end
					end
					CH_PWM: begin
						next_out[gi] = next_cnt < ccr[gi];
						cmp_ev[gi] = tick && next_cnt == ccr[gi];
					end
					CH_OPM: begin
						next_out[gi] = (next_cnt >= ccr[gi]) && next_ctrl[CTRL_EN];
						cmp_ev[gi] = tick && next_cnt == ccr[gi];
					end
					default: next_out[gi] = 1'b0;
				endcase
			end
			assign ch_oe_n[gi] = (ch_mode(chcfg, gi) == CH_CAP);
		end
	endgenerate
	assign ev = {cap_ev | cmp_ev, upd};

	// bus
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			req <= '0;
		end else if (hready) begin
			req <= '{htrans: (hsel ? htrans : 2'h0), hwrite: hwrite, addr: haddr};
		end
	end
	assign wr_ph = req.htrans[1] && req.hwrite;
	assign waddr = req.addr;

	always_comb begin
		next_ctrl = ctrl;
		next_psc = psc;
		next_arr = arr;
		next_chcfg = chcfg;
		next_mask = mask;
		next_stat = stat;
		if (wr_ph) begin
			case (waddr)
				OFF_CTRL: next_ctrl = hwdata & 32'h0000007F;
				OFF_PSC: next_psc = hwdata[15:0];
				OFF_ARR: next_arr = hwdata & CMASK;
				OFF_CHCFG: next_chcfg = hwdata & 32'h00007777;
				OFF_MASK: next_mask = hwdata[4:0];
				OFF_STAT: next_stat = stat & ~hwdata[4:0];
				default: next_stat = stat;
			endcase
		end
		// one-pulse: stop the counter at the update
		if (upd && ctrl[CTRL_OPM]) begin
			next_ctrl[CTRL_EN] = 1'b0;
		end
		// set wins over write-one-to-clear
		next_stat = next_stat | ev;
	end

	always_comb begin
		case (req.addr)
			OFF_CTRL: rdata_n = ctrl;
			OFF_PSC: rdata_n = {16'h0000, psc};
			OFF_ARR: rdata_n = arr;
			OFF_CNT: rdata_n = cnt;
			OFF_STAT: rdata_n = {27'h0, stat};
			OFF_MASK: rdata_n = {27'h0, mask};
			OFF_CHCFG: rdata_n = chcfg;
			OFF_CCR0: rdata_n = ccr[0];
			OFF_CCR0 + 8'h04: rdata_n = ccr[1];
			OFF_CCR0 + 8'h08: rdata_n = ccr[2];
			OFF_CCR0 + 8'h0C: rdata_n = ccr[3];
			default: rdata_n = 32'h0;
		endcase
	end
	assign hrdata = rdata_n;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl <= 32'h0;
			psc <= 16'h0000;
			arr <= ARR_RST;
			cnt <= 32'h0;
			chcfg <= 32'h0;
			stat <= 5'h00;
			mask <= 5'h00;
			pcnt <= 16'h0000;
			dir <= 1'b0;
			ch_q <= 4'h0;
			for (int i = 0; i < NCH; i++) begin
				ccr[i] <= 32'h0;
			end
		end else begin
			ctrl <= next_ctrl;
			psc <= next_psc;
			arr <= next_arr;
			cnt <= (wr_ph && waddr == OFF_CNT) ? (hwdata & CMASK) : next_cnt;
			chcfg <= next_chcfg;
			stat <= next_stat;
			mask <= next_mask;
			pcnt <= next_pcnt;
			dir <= next_dir;
			ch_q <= next_out;
			for (int i = 0; i < NCH; i++) begin
				if (wr_ph && waddr == OFF_CCR0 + 8'(i * 4)) begin
					ccr[i] <= hwdata & CMASK;
				end else begin
					ccr[i] <= next_ccr[i];
				end
			end
		end
	end

	// checks
	a_irq_gate: assert property (@(posedge clk) disable iff (!rst_n)
		((|(ev & mask)) && !(wr_ph && waddr == OFF_MASK)) |=> irq)
		else $error("enabled event did not raise irq");
	a_up_wrap: assert property (@(posedge clk) disable iff (!rst_n)
		(tick && mode == MODE_UP && src == SRC_INT && cnt >= arr && !wr_ph) |=> cnt == 32'h0)
		else $error("up overflow did not reload zero");
	a_dn_reload: assert property (@(posedge clk) disable iff (!rst_n)
		(tick && mode == MODE_DOWN && src == SRC_INT && cnt == 32'h0 && !wr_ph)
		|=> cnt == (arr & CMASK)) else $error("down underflow reload wrong");
	a_upd_flag: assert property (@(posedge clk) disable iff (!rst_n)
		upd |=> stat[ST_UPD]) else $error("update flag not set");
	a_freeze_hold: assert property (@(posedge clk) disable iff (!rst_n)
		(frozen && !wr_ph) |=> $stable(cnt)) else $error("counter moved while frozen");
	a_psc_idle: assert property (@(posedge clk) disable iff (!rst_n)
		(run && src == SRC_INT && pcnt < psc) |-> !tick) else $error("early tick");
	a_narrow_cnt: assert property (@(posedge clk) disable iff (!rst_n)
		(cnt & ~CMASK) == 32'h0) else $error("counter exceeds width");
	a_cap_load: assert property (@(posedge clk) disable iff (!rst_n)
		(cap_ev[0] && !(wr_ph && waddr == OFF_CCR0)) |=> (ccr[0] == $past(cnt)) && stat[ST_CC0])
		else $error("capture not loaded");
	a_dma_req: assert property (@(posedge clk) disable iff (!rst_n)
		(upd && mask[0] && !(wr_ph && waddr == OFF_MASK)) |=> dma_req[0])
		else $error("update dma request missing");
	a_trig_out: assert property (@(posedge clk) disable iff (!rst_n)
		trig_out |-> tick) else $error("trigger out without a counter step");
	a_ctr_turn: assert property (@(posedge clk) disable iff (!rst_n)
		(tick && mode == MODE_CTR && src == SRC_INT && !dir && cnt >= arr && !wr_ph)
		|=> dir && (cnt == $past(cnt) - 32'h1)) else $error("centre count did not turn");
endmodule : gpt_timer
`default_nettype wire

// *** testbench/gpt_enc_model.sv ***
// Purpose: encoder and hall sensor stand-in on the timer channel pins
// Assumes: pins change right after a clock edge, slowly against the input sync
// Notes: loads on the channel outputs are judged by the bench
`timescale 1ns/1ps
`default_nettype none
module gpt_enc_model (
	// timing
	input wire logic clk,
	// sensor pins
	output logic [3:0] pins
);
	initial pins = 4'h0;
	// gray steps on A/B; the leading phase sets direction
	task automatic turn(input logic fwd, input int n);
		for (int i = 0; i < n; i++) begin
			repeat (4) @(posedge clk);
			if (fwd == (pins[0] == pins[1])) pins[0] <= ~pins[0];
			else pins[1] <= ~pins[1];
		end
		repeat (4) @(posedge clk);
	endtask : turn
	// hall levels held long enough to pass the two-flop sync
	task automatic hall(input logic [2:0] v);
		repeat (4) @(posedge clk);
		pins[2:0] <= v;
		repeat (4) @(posedge clk);
	endtask : hall
endmodule : gpt_enc_model
`default_nettype wire

// *** testbench/tb.sv ***
// Purpose: self-checking bench for the general purpose timer
// Assumes: zero wait AHB-Lite slave, 125 MHz clock
// Notes: one task per scenario, long prescales kept short
`timescale 1ns/1ps
`default_nettype none
module tb;
	import gpt_pkg::*;
	logic clk, rst_n, hsel, hwrite, hreadyout, hresp, dbg_halt, trig_in, trig_out, irq;
	logic [7:0] haddr;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] hwdata, hrdata, q;
	logic [3:0] ch_in, ch_out, ch_oe_n;
	logic [4:0] dma_req;
	int mismatches = 0;
	int n_compared = 0;
	int cyc = 0;
	int n_trig = 0;
	gpt_timer #(.WIDE(1'b1)) u_dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ch_in(ch_in), .ch_out(ch_out),
		.ch_oe_n(ch_oe_n), .dbg_halt(dbg_halt), .trig_in(trig_in), .trig_out(trig_out),
		.dma_req(dma_req), .irq(irq));
	gpt_enc_model u_enc (.clk(clk), .pins(ch_in));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic stop_test;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : stop_test
	// a hang is cut short well past the thousand or so cycles the run needs
	always @(posedge clk) begin
		cyc++;
		if (trig_out === 1'b1) n_trig++;
		if (cyc == 20000) begin
			mismatches++;
			stop_test();
		end
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask : xfer
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a, input string nm, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(nm, e, q);
	endtask : rd
	task automatic wait_irq;
		for (int i = 0; i < 2000 && irq !== 1'b1; i++) @(posedge clk);
	endtask : wait_irq
	task automatic t_regs;
		rd(OFF_ARR, "arr reset", ARR_RST);
		rd(OFF_CTRL, "ctrl reset", 32'h0);
		chk("oe_n reset", 32'hF, {28'h0, ch_oe_n});
		chk("hresp okay", 32'h0, {31'h0, hresp});
		wr(8'h40, 32'h12345678);
		rd(8'h40, "unmapped", 32'h0);
		wr(OFF_PSC, 32'hFFFFFFFF);
		rd(OFF_PSC, "psc width", 32'h0000FFFF);
		$display("t_regs done");
	endtask : t_regs
	task automatic t_up;
		wr(OFF_PSC, 32'd99);
		wr(OFF_ARR, 32'h3);
		wr(OFF_CNT, 32'h2);
		wr(OFF_MASK, 32'h1);
		n_trig = 0;
		wr(OFF_CTRL, 32'h1);
		wait_irq();
		rd(OFF_CNT, "up reload", 32'h0);
		chk("irq", 32'h1, {31'h0, irq});
		chk("dma", 32'h1, {27'h0, dma_req});
		chk("trig pulses", 32'h1, n_trig);
		wr(OFF_MASK, 32'h0);
		rd(OFF_STAT, "sticky", 32'h1);
		chk("masked irq", 32'h0, {31'h0, irq});
		wr(OFF_CTRL, 32'h0);
		wr(OFF_STAT, 32'h1);
		rd(OFF_STAT, "w1c", 32'h0);
		$display("t_up done");
	endtask : t_up
	task automatic t_down;
		wr(OFF_ARR, 32'd20);
		wr(OFF_CNT, 32'h1);
		wr(OFF_MASK, 32'h1);
		wr(OFF_CTRL, 32'h3);
		wait_irq();
		rd(OFF_CNT, "down reload", 32'd20);
		wr(OFF_CTRL, 32'h0);
		wr(OFF_STAT, 32'h1F);
		wr(OFF_MASK, 32'h0);
		$display("t_down done");
	endtask : t_down
	task automatic t_frz;
		wr(OFF_PSC, 32'h0);
		wr(OFF_ARR, 32'hFFFFFFFF);
		wr(OFF_CNT, 32'h0);
		dbg_halt <= 1'b1;
		wr(OFF_CTRL, 32'h9);
		repeat (20) @(posedge clk);
		rd(OFF_CNT, "frozen", 32'h0);
		dbg_halt <= 1'b0;
		repeat (20) @(posedge clk);
		xfer(1'b0, OFF_CNT, 32'h0);
		chk("resumed", 32'd21, q);
		wr(OFF_CTRL, 32'h0);
		wr(OFF_STAT, 32'h1F);
		$display("t_frz done");
	endtask : t_frz
	task automatic t_sense;
		wr(OFF_CNT, 32'd100);
		wr(OFF_CTRL, 32'h11);
		u_enc.turn(1'b1, 4);
		xfer(1'b0, OFF_CNT, 32'h0);
		chk("enc fwd", 32'd104, q);
		u_enc.turn(1'b0, 4);
		rd(OFF_CNT, "enc back", 32'd100);
		wr(OFF_CTRL, 32'h31);
		u_enc.hall(3'b001);
		u_enc.hall(3'b011);
		u_enc.hall(3'b010);
		rd(OFF_CNT, "hall", 32'd103);
		rd(OFF_STAT, "captures", 32'h6);
		wr(OFF_CTRL, 32'h0);
		$display("t_sense done");
	endtask : t_sense
	task automatic t_trig;
		wr(OFF_CNT, 32'h0);
		wr(OFF_CTRL, 32'h21);
		for (int i = 0; i < 3; i++) begin
			trig_in <= 1'b1;
			repeat (3) @(posedge clk);
			trig_in <= 1'b0;
			repeat (3) @(posedge clk);
		end
		repeat (4) @(posedge clk);
		rd(OFF_CNT, "trig count", 32'h3);
		wr(OFF_CTRL, 32'h0);
		$display("t_trig done");
	endtask : t_trig
	task automatic t_pwm;
		int hi;
		int tg;
		logic prev;
		wr(OFF_ARR, 32'h9);
		wr(OFF_CCR0, 32'h5);
		wr(OFF_CCR0 + 8'h04, 32'h3);
		wr(OFF_CHCFG, 32'h12);
		wr(OFF_CNT, 32'h0);
		wr(OFF_CTRL, 32'h1);
		repeat (20) @(posedge clk);
		hi = 0;
		tg = 0;
		prev = ch_out[1];
		for (int i = 0; i < 100; i++) begin
			@(posedge clk);
			hi += int'(ch_out[0]);
			tg += int'(ch_out[1] != prev);
			prev = ch_out[1];
		end
		chk("pwm high", 32'd50, hi);
		chk("toggles", 32'd10, tg);
		chk("oe_n", 32'hC, {28'h0, ch_oe_n});
		$display("t_pwm done");
	endtask : t_pwm
	// centre-aligned count 0..4..0 with PWM, then a single one-pulse run
	task automatic t_ctr;
		int hi;
		int up;
		wr(OFF_CTRL, 32'h0);
		wr(OFF_PSC, 32'h0);
		wr(OFF_ARR, 32'h4);
		wr(OFF_CCR0, 32'h2);
		wr(OFF_CHCFG, 32'h2);
		wr(OFF_CNT, 32'h0);
		wr(OFF_CTRL, 32'h5);
		repeat (16) @(posedge clk);
		hi = 0;
		up = 0;
		for (int i = 0; i < 80; i++) begin
			@(posedge clk);
			hi += int'(ch_out[0]);
			up += int'(trig_out);
		end
		chk("ctr high", 32'd30, hi);
		chk("ctr updates", 32'd20, up);
		wr(OFF_CTRL, 32'h0);
		wr(OFF_ARR, 32'h5);
		wr(OFF_CCR0, 32'h3);
		wr(OFF_CHCFG, 32'h3);
		wr(OFF_CNT, 32'h0);
		wr(OFF_CTRL, 32'h41);
		hi = 0;
		for (int i = 0; i < 20; i++) begin
			@(posedge clk);
			hi += int'(ch_out[0]);
		end
		chk("opm pulse", 32'd3, hi);
		rd(OFF_CTRL, "opm stop", 32'h40);
		rd(OFF_CNT, "opm rest", 32'h0);
		$display("t_ctr done");
	endtask : t_ctr
	initial begin
		rst_n = 1'b0;
		hsel = 1'b0;
		hwrite = 1'b0;
		haddr = 8'h00;
		htrans = 2'h0;
		hsize = 3'h2;
		hwdata = 32'h0;
		dbg_halt = 1'b0;
		trig_in = 1'b0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_regs();
		t_up();
		t_down();
		t_frz();
		t_sense();
		t_trig();
		t_pwm();
		t_ctr();
		stop_test();
	end
endmodule : tb
`default_nettype wire
